// *** bench/integrity_monitor_test.sv ***
/*
  Self-checking bench of the list control: register calls over Avalon-MM and list runs.
  Assumes the memory model answers the master port and the bench plays the hash core.
*/
`timescale 1ns/1ns
`include "integrity_monitor_defs.svh"
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module integrity_monitor_test;
  // ==========================================================================
  // Clock, reset, design inputs and outputs.
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic digest_mismatch_i = 1'b0;
  logic [31:0] avs_readdata_o, mem_addr_o, mem_rdata_i, q;
  logic avs_waitrequest_o, mem_rd_o, mem_wr_o, mem_ack_i, hash_start_o;
  logic digest_write_o, digest_compare_o, mismatch_irq_o;
  int bad_count = 0;
  int comparisons = 0;
  int starts = 0;
  int idle = 0;
  int max_idle = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  integrity_monitor u_integrity_monitor (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .hash_start_o(hash_start_o), .digest_write_o(digest_write_o),
    .digest_compare_o(digest_compare_o), .digest_mismatch_i(digest_mismatch_i),
    .mismatch_irq_o(mismatch_irq_o));
  memory_model u_memory_model (.ref_clk_i(ref_clk_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // ==========================================================================
  // Count hash starts and keep the longest quiet span that ends in a memory request.
  always @(posedge ref_clk_i) begin
    if (hash_start_o === 1'b1) begin
      starts <= starts + 1;
      idle <= 0;
    end else if (mem_rd_o === 1'b1 || mem_wr_o === 1'b1) begin
      if (idle > max_idle) max_idle <= idle;
      idle <= 0;
    end else idle <= idle + 1;
  end

  // One register access: waitrequest is sampled at each rising edge; data is taken where it is seen low.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 64) bad_count++;
  endtask

  // Write a descriptor at slot k: block address, region config word and link word.
  task automatic desc(input int k, input logic [31:0] blk, input logic [31:0] cfg, input logic [31:0] link);
    u_memory_model.mem[k * 4] = blk;
    u_memory_model.mem[k * 4 + 1] = cfg;
    u_memory_model.mem[k * 4 + 3] = link;
  endtask

  // Clean restart: soft reset, bases, shortest period, config, counters, then enable.
  task automatic start(input logic [31:0] cfg);
    acc(1'b1, `OFS_CONTROL, 32'h4);
    acc(1'b1, `OFS_DESC_BASE, 32'h0);
    acc(1'b1, `OFS_DIGEST_BASE, 32'h380);
    acc(1'b1, `OFS_PERIOD, 32'h0);
    acc(1'b1, `OFS_CONFIG, cfg);
    starts = 0;
    idle = 0;
    max_idle = 0;
    u_memory_model.n_wr = 0;
    u_memory_model.n_rd = 0;
    acc(1'b1, `OFS_CONTROL, 32'h1);
  endtask

  // Wait, bounded, for the given counts of digest writes and reads.
  task automatic wait_mem(input int w, input int r);
    int n;
    for (n = 0; n < 8000 && (u_memory_model.n_wr < w || u_memory_model.n_rd < r); n++) @(posedge ref_clk_i);
    if (n >= 8000) bad_count++;
    @(negedge ref_clk_i);
  endtask

  // Program the period and read back its clamped value.
  task automatic per(input logic [31:0] cfg, input logic [31:0] w, input logic [31:0] e);
    acc(1'b1, `OFS_CONFIG, cfg);
    acc(1'b1, `OFS_PERIOD, w);
    acc(1'b0, `OFS_PERIOD, 32'h0);
    `CHECK(q, e)
  endtask

  task automatic end_of_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: far beyond the few thousand cycles the sequence needs.
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    acc(1'b0, `OFS_UNDEF_STATUS, 32'h0);
    `CHECK(q, 32'h0)
    per(32'h0, 32'h64, 32'h64);
    per(32'h0, 32'h0, 32'h55);
    per(32'h0, 32'h3e8, 32'hd1);
    per(32'h2000, 32'h0, 32'h48);
    per(32'h2000, 32'h3e8, 32'hc2);
    // Single contiguous region with write-back, plus two undefined accesses in flight.
    desc(0, 32'h200, 32'h400, 32'h0);
    start(32'h30);
    acc(1'b1, `OFS_CONFIG, 32'h30);
    acc(1'b0, `OFS_CONTROL, 32'h0);
    wait_mem(1, 0);
    `CHECK(u_memory_model.last_dig, 32'h380)
    repeat (600) @(posedge ref_clk_i);
    `CHECK(starts, 1)
    `CHECK(u_memory_model.n_wr, 1)
    `CHECK((max_idle >= 85 && max_idle <= 90), 1'b1)
    acc(1'b1, `OFS_IRQ_STATUS, 32'h01000000);
    acc(1'b0, `OFS_IRQ_STATUS, 32'h0);
    `CHECK(q[24], 1'b1)
    acc(1'b0, `OFS_UNDEF_STATUS, 32'h0);
    `CHECK(q[2:0], `UAT_CFG)
    acc(1'b1, `OFS_CONTROL, 32'h4);
    acc(1'b0, `OFS_IRQ_STATUS, 32'h0);
    `CHECK(q[24], 1'b0)
    acc(1'b0, `OFS_STATUS, 32'h0);
    acc(1'b0, `OFS_UNDEF_STATUS, 32'h0);
    `CHECK(q[2:0], `UAT_RDWO)
    // Two compared regions that wrap, slow memory, burden field 8, digests that differ.
    desc(0, 32'h200, 32'h100, 32'h0);
    desc(1, 32'h240, 32'h300, 32'h0);
    u_memory_model.delay = 3;
    @(posedge ref_clk_i);
    digest_mismatch_i <= 1'b1;
    start(32'h80);
    wait_mem(0, 3);
    `CHECK(u_memory_model.last_dig, 32'h380)
    `CHECK(u_memory_model.n_wr, 0)
    `CHECK(mismatch_irq_o, 1'b1)
    `CHECK((max_idle >= 256 && max_idle <= 262), 1'b1)
    acc(1'b1, `OFS_CONTROL, 32'h2);
    digest_mismatch_i <= 1'b0;
    acc(1'b1, `OFS_IRQ_STATUS, 32'h1);
    acc(1'b0, `OFS_IRQ_STATUS, 32'h0);
    `CHECK(q[0], 1'b0)
    // Automatic switch: descriptor end and compare flags must not steer either pass.
    u_memory_model.delay = 0;
    desc(0, 32'h200, 32'h400, 32'h0);
    desc(1, 32'h240, 32'h300, 32'h0);
    start(32'h130);
    wait_mem(2, 2);
    `CHECK(u_memory_model.n_wr, 2)
    `CHECK(u_memory_model.last_dig, 32'h3a0)
    `CHECK(mismatch_irq_o, 1'b0)
    acc(1'b1, `OFS_CONTROL, 32'h2);
    // Non-contiguous write-back: region 0 continues through a secondary item.
    desc(0, 32'h200, 32'h0, 32'h40);
    desc(4, 32'h280, 32'h0, 32'h0);
    desc(1, 32'h240, 32'h400, 32'h0);
    start(32'h30);
    wait_mem(2, 0);
    repeat (300) @(posedge ref_clk_i);
    `CHECK(starts, 3)
    `CHECK(u_memory_model.last_dig, 32'h3a0)
    // A reserved bit in a loaded region config word.
    desc(0, 32'h200, 32'h401, 32'h0);
    start(32'h30);
    repeat (300) @(posedge ref_clk_i);
    acc(1'b0, `OFS_UNDEF_STATUS, 32'h0);
    `CHECK(q[2:0], `UAT_DESC)
    acc(1'b0, `OFS_IRQ_STATUS, 32'h0);
    `CHECK(q[24], 1'b1)
    end_of_test();
  end
endmodule
`default_nettype wire

// *** bench/memory_model.sv ***
/*
  Behavioural system memory on the list control's master port.
  Assumes each request is held until the one-cycle ack and that digests sit at 0x380 and above.
*/
`timescale 1ns/1ns
`default_nettype none
module memory_model (
  // Clock.
  input wire logic ref_clk_i,
  // Master requests.
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [31:0] mem_addr_i,
  // Answers.
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  // ==========================================================================
  // Storage, answer delay and digest counters read by the bench.
  logic [31:0] mem [0:255];
  logic [31:0] last_dig = 32'h0;
  int delay = 0;
  int cnt = 0;
  int n_wr = 0;
  int n_rd = 0;

  // Memory starts cleared so that no unknown reaches the sequencer.
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 32'h0;
    foreach (mem[k]) mem[k] = 32'h0;
  end

  // Answer after the set delay; between answers the data lines toggle so stale data is never mistaken for valid.
  always @(posedge ref_clk_i) begin
    if ((mem_rd_i | mem_wr_i) && !mem_ack_o && cnt >= delay) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem_rd_i ? mem[mem_addr_i[9:2]] : ~mem_rdata_o;
      cnt <= 0;
      if (mem_wr_i) begin
        n_wr <= n_wr + 1;
        last_dig <= mem_addr_i;
      end else if (mem_addr_i[9:7] == 3'h7) begin
        n_rd <= n_rd + 1;
        last_dig <= mem_addr_i;
      end
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_rd_i | mem_wr_i) cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** verilog/integrity_monitor.sv ***
/*
  Region list sequencer of the integrity monitor with an Avalon-MM slave and a
  simple read/write memory master port. The hash core sits outside; this block
  times its period and signals digest write-back or compare.
  Assumes memory answers each master access with mem_ack_i for one cycle.
*/
// Behaviour
// R1 - Software sets the hash period per block in a register.
// R2 - SHA1 period at least 85 cycles plus 2 sync cycles.
// R3 - SHA1 period at most 209 cycles plus 2 sync cycles.
// R4 - SHA256/224 period at least 72 cycles plus 2 sync cycles.
// R5 - SHA256/224 period at most 194 cycles plus 2 sync cycles.
// R6 - Auto mode first pass writes digests back with end flag cleared.
// R7 - Auto mode at wrap switches to comparing with end flag cleared.
// R8 - Auto mode ignores descriptor compare and end flags.
// R9 - Software builds a one-item list for a single contiguous write-back region.
// R10 - Software links a secondary list for a non-contiguous region.
// R11 - Compare flag set: computed digest is compared with stored digest.
// R12 - Write-back list ends after descriptor flagged end-of-monitoring.
// R13 - Compare list wraps continuously; mismatch raises the interrupt.
// R14 - Non-contiguous write-back follows secondary lists and stores digests.
// R15 - Non-contiguous compare follows secondary lists and keeps monitoring.
// R16 - Undefined access sets the flag and records its kind.
// R17 - Only the first access kind is kept until cleared.
// R18 - Loaded descriptor with reserved bit set is undefined.
// R19 - Config, descriptor or digest base written while monitoring is undefined.
// R20 - Reading a write-only register is undefined.
// R21 - Only the soft reset bit clears flag and kind.
// R22 - Gap of two to the bus burden power between blocks.
// R23 - Digest address is base plus region identifier shifted by five.
// R24 - After a wrap descriptor monitoring restarts at the list head.
// R25 - After an end descriptor, unless disabled, the sequencer idles.
`timescale 1ns/1ns
`include "integrity_monitor_defs.svh"
`default_nettype none
module integrity_monitor (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Memory master.
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Hash core handshake.
  output logic hash_start_o,
  output logic digest_write_o,
  output logic digest_compare_o,
  input wire logic digest_mismatch_i,
  // Status.
  output logic mismatch_irq_o
);
  integrity_monitor_pkg::state_t state_reg;
  logic [31:0] config_reg, desc_base_reg, digest_base_reg, period_reg;
  logic [31:0] desc_ptr_reg, region_cfg_reg, link_reg, blk_ptr_reg;
  logic [7:0] rid_reg;
  logic [15:0] cnt_reg;
  logic enable_reg, auto_cmp_reg, in_sec_reg, flag_reg, mismatch_reg, ack_reg;
  logic [2:0] type_reg;
  logic [8:0] eff_period;
  logic [31:0] rd_mux;
  logic is_sha1, bus_req, monitoring, cmp_sel, eom_sel, undef_hit;
  logic [2:0] undef_kind;

  // ==========================================================================
  // Bus slave: one wait cycle, answer on the second cycle of the request.
  assign bus_req = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  // The ack register releases the bus for exactly one edge.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // Write access strobes at the accepting edge.
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = avs_write_i & ack_reg & (avs_address_i == ofs);
  endfunction

  assign monitoring = (state_reg != integrity_monitor_pkg::ST_IDLE);
  // Written out, not through the function: a continuous assignment would miss the function's inner reads.
  wire srst = avs_write_i & ack_reg & (avs_address_i == `OFS_CONTROL) & avs_writedata_i[`CTL_SRST_BIT];

  // Register file; base registers stay frozen while monitoring.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_reg <= 32'h0;
      desc_base_reg <= 32'h0;
      digest_base_reg <= 32'h0;
      period_reg <= 32'h0;
    end else if (srst) begin
      config_reg <= 32'h0;
      desc_base_reg <= 32'h0;
      digest_base_reg <= 32'h0;
      period_reg <= 32'h0;
    end else if (!monitoring) begin
      if (wr_hit(`OFS_CONFIG)) config_reg <= avs_writedata_i;
      if (wr_hit(`OFS_DESC_BASE)) desc_base_reg <= {avs_writedata_i[31:6], 6'h00};
      if (wr_hit(`OFS_DIGEST_BASE)) digest_base_reg <= {avs_writedata_i[31:7], 7'h00};
      if (wr_hit(`OFS_PERIOD)) period_reg <= avs_writedata_i; // R1
    end
  end

  // Read data; reading write-only control or status registers returns zero.
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `OFS_CONFIG: rd_mux = config_reg;
      `OFS_IRQ_STATUS: rd_mux = {7'h0, flag_reg, 23'h0, mismatch_reg};
      `OFS_UNDEF_STATUS: rd_mux = {29'h0, type_reg};
      `OFS_DESC_BASE: rd_mux = desc_base_reg;
      `OFS_DIGEST_BASE: rd_mux = digest_base_reg;
      `OFS_PERIOD: rd_mux = {23'h0, eff_period};
      8'h0c: rd_mux = {31'h0, enable_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (bus_req && avs_read_i) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // ==========================================================================
  // Undefined access detection, first kind kept.
  always_comb begin
    undef_kind = 3'h0;
    if (state_reg == integrity_monitor_pkg::ST_CFG && mem_ack_i && |(mem_rdata_i & `RC_RSVD_MASK)) begin
      undef_kind = `UAT_DESC; // R18
    end else if (monitoring && wr_hit(`OFS_CONFIG)) begin
      undef_kind = `UAT_CFG; // R19
    end else if (monitoring && wr_hit(`OFS_DESC_BASE)) begin
      undef_kind = `UAT_DSCR; // R19
    end else if (monitoring && wr_hit(`OFS_DIGEST_BASE)) begin
      undef_kind = `UAT_HASH; // R19
    end else if (avs_read_i && ack_reg && (avs_address_i == `OFS_CONTROL || avs_address_i == `OFS_STATUS)) begin
      undef_kind = `UAT_RDWO; // R20
    end
  end
  assign undef_hit = (undef_kind != 3'h0);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
      type_reg <= 3'h0;
    end else if (srst) begin
      flag_reg <= 1'b0; // R21
      type_reg <= 3'h0; // R21
    end else if (undef_hit && !flag_reg) begin
      flag_reg <= 1'b1; // R16
      type_reg <= undef_kind; // R17
    end
  end

  // ==========================================================================
  // Enable control.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_reg <= 1'b0;
    end else if (srst || (wr_hit(`OFS_CONTROL) && avs_writedata_i[`CTL_DISABLE_BIT])) begin
      enable_reg <= 1'b0;
    end else if (wr_hit(`OFS_CONTROL) && avs_writedata_i[`CTL_ENABLE_BIT]) begin
      enable_reg <= 1'b1;
    end else if (state_reg == integrity_monitor_pkg::ST_NEXT && eom_sel) begin
      enable_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Period clamp per algorithm, then start synchronisation added.
  assign is_sha1 = (config_reg[`CFG_ALGO_LSB +: 3] == 3'h0);
  always_comb begin
    eff_period = period_reg[8:0];
    if (is_sha1) begin
      if (period_reg < `SHA1_MIN_CYC) eff_period = 9'(`SHA1_MIN_CYC); // R2
      else if (period_reg > `SHA1_MAX_CYC) eff_period = 9'(`SHA1_MAX_CYC); // R3
    end else begin
      if (period_reg < `SHA2_MIN_CYC) eff_period = 9'(`SHA2_MIN_CYC); // R4
      else if (period_reg > `SHA2_MAX_CYC) eff_period = 9'(`SHA2_MAX_CYC); // R5
    end
  end

  // Context selection: auto mode overrides both descriptor flags, so an auto run only ends on disable or soft reset.
  assign cmp_sel = config_reg[`CFG_AUTO_BIT] ? auto_cmp_reg : region_cfg_reg[`RC_CMP_BIT]; // R8 R11
  assign eom_sel = ~config_reg[`CFG_EOMDIS_BIT] & ~config_reg[`CFG_AUTO_BIT] & region_cfg_reg[`RC_EOM_BIT]; // R6 R7 R8

  // ==========================================================================
  // List sequencer.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= integrity_monitor_pkg::ST_IDLE;
      desc_ptr_reg <= 32'h0;
      region_cfg_reg <= 32'h0;
      link_reg <= 32'h0;
      blk_ptr_reg <= 32'h0;
      rid_reg <= 8'h0;
      cnt_reg <= 16'h0;
      auto_cmp_reg <= 1'b0;
      in_sec_reg <= 1'b0;
    end else if (srst || !enable_reg) begin
      state_reg <= integrity_monitor_pkg::ST_IDLE;
      desc_ptr_reg <= desc_base_reg;
      rid_reg <= 8'h0;
      auto_cmp_reg <= 1'b0; // R6
      in_sec_reg <= 1'b0;
    end else begin
      case (state_reg)
        integrity_monitor_pkg::ST_IDLE: begin
          state_reg <= integrity_monitor_pkg::ST_CFG;
        end
        integrity_monitor_pkg::ST_CFG: begin
          if (mem_ack_i) begin
            if (!in_sec_reg) region_cfg_reg <= mem_rdata_i;
            state_reg <= integrity_monitor_pkg::ST_LINK;
          end
        end
        integrity_monitor_pkg::ST_LINK: begin
          if (mem_ack_i) begin
            link_reg <= config_reg[`CFG_SLBDIS_BIT] ? 32'h0 : {mem_rdata_i[31:2], 2'h0}; // R10 R14 R15
            state_reg <= integrity_monitor_pkg::ST_BLK;
          end
        end
        integrity_monitor_pkg::ST_BLK: begin
          if (mem_ack_i) begin
            blk_ptr_reg <= mem_rdata_i;
            cnt_reg <= 16'(eff_period) + 16'(`SYNC_CYC);
            state_reg <= integrity_monitor_pkg::ST_HASH;
          end
        end
        integrity_monitor_pkg::ST_HASH: begin
          if (cnt_reg > 16'h1) begin
            cnt_reg <= cnt_reg - 16'h1;
          end else if (link_reg != 32'h0) begin
            cnt_reg <= 16'(32'h1 << config_reg[`CFG_BBC_LSB +: 4]); // R22
            state_reg <= integrity_monitor_pkg::ST_GAP;
          end else begin
            state_reg <= integrity_monitor_pkg::ST_DIG;
          end
        end
        integrity_monitor_pkg::ST_DIG: begin
          if (mem_ack_i) begin
            cnt_reg <= 16'(32'h1 << config_reg[`CFG_BBC_LSB +: 4]); // R22
            state_reg <= integrity_monitor_pkg::ST_NEXT;
          end
        end
        integrity_monitor_pkg::ST_GAP: begin
          if (cnt_reg > 16'h1) begin
            cnt_reg <= cnt_reg - 16'h1;
          end else begin
            desc_ptr_reg <= link_reg; // R14 R15
            in_sec_reg <= 1'b1;
            state_reg <= integrity_monitor_pkg::ST_CFG;
          end
        end
        // The gap runs before the next fetch, so other masters get the system bus in between.
        integrity_monitor_pkg::ST_NEXT: begin
          in_sec_reg <= 1'b0;
          if (cnt_reg > 16'h1) begin
            cnt_reg <= cnt_reg - 16'h1;
          end else if (region_cfg_reg[`RC_WRAP_BIT]) begin
            desc_ptr_reg <= desc_base_reg; // R24 R13 R15
            rid_reg <= 8'h0;
            if (config_reg[`CFG_AUTO_BIT]) auto_cmp_reg <= 1'b1; // R7
            state_reg <= integrity_monitor_pkg::ST_CFG;
          end else if (eom_sel) begin
            state_reg <= integrity_monitor_pkg::ST_IDLE; // R25 R12
          end else begin
            desc_ptr_reg <= desc_base_reg + {20'h0, rid_reg + 8'h1, 4'h0};
            rid_reg <= rid_reg + 8'h1;
            state_reg <= integrity_monitor_pkg::ST_CFG;
          end
        end
        default: state_reg <= integrity_monitor_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Memory master and hash handshake; descriptor words at ptr, ptr+4, ptr+c.
  always_comb begin
    mem_rd_o = 1'b0;
    mem_wr_o = 1'b0;
    mem_addr_o = 32'h0;
    case (state_reg)
      integrity_monitor_pkg::ST_CFG: begin
        mem_rd_o = 1'b1;
        mem_addr_o = desc_ptr_reg + 32'h4;
      end
      integrity_monitor_pkg::ST_LINK: begin
        mem_rd_o = 1'b1;
        mem_addr_o = desc_ptr_reg + 32'hc;
      end
      integrity_monitor_pkg::ST_BLK: begin
        mem_rd_o = 1'b1;
        mem_addr_o = desc_ptr_reg;
      end
      integrity_monitor_pkg::ST_DIG: begin
        mem_rd_o = cmp_sel;
        mem_wr_o = ~cmp_sel;
        mem_addr_o = digest_base_reg + ({24'h0, rid_reg} << `DIGEST_SHIFT); // R23
      end
      default: mem_addr_o = 32'h0;
    endcase
  end
  assign hash_start_o = (state_reg == integrity_monitor_pkg::ST_BLK) & mem_ack_i;
  assign digest_write_o = (state_reg == integrity_monitor_pkg::ST_DIG) & ~cmp_sel;
  assign digest_compare_o = (state_reg == integrity_monitor_pkg::ST_DIG) & cmp_sel; // R11

  // Mismatch flag; a new mismatch wins over the write that clears it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mismatch_reg <= 1'b0;
    end else if (digest_compare_o && mem_ack_i && digest_mismatch_i) begin
      mismatch_reg <= 1'b1; // R13
    end else if (srst || (wr_hit(`OFS_IRQ_STATUS) && avs_writedata_i[0])) begin
      mismatch_reg <= 1'b0;
    end
  end
  assign mismatch_irq_o = mismatch_reg;

  // ==========================================================================
  // Assertions.
  // Period clamps: any value that software writes must land inside the legal window.
  a_period_sha1: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R2
    is_sha1 |-> eff_period >= 9'(`SHA1_MIN_CYC)) else $error("sha1 period too short");
  a_period_sha1_max: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R3
    is_sha1 |-> eff_period <= 9'(`SHA1_MAX_CYC)) else $error("sha1 period too long");
  a_period_sha2: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R4
    !is_sha1 |-> eff_period >= 9'(`SHA2_MIN_CYC)) else $error("sha2 period too short");
  a_period_sha2_max: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R5
    !is_sha1 |-> eff_period <= 9'(`SHA2_MAX_CYC)) else $error("sha2 period too long");
  // Undefined access reporting, digest address and auto-compare write-back checks.
  a_undef_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R17
    flag_reg && !srst |=> $stable(type_reg) && flag_reg) else $error("access kind changed");
  a_undef_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R16
    undef_hit && !flag_reg && !srst |=> flag_reg && type_reg != 3'h0) else $error("undefined access lost");
  a_digest_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R23
    state_reg == integrity_monitor_pkg::ST_DIG |-> mem_addr_o[4:0] == digest_base_reg[4:0])
    else $error("digest address wrong");
  a_auto_compare: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R7
    auto_cmp_reg && digest_write_o |-> 1'b0) else $error("write-back in auto compare");
  a_srst_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R21
    srst |=> !flag_reg && type_reg == 3'h0) else $error("soft reset did not clear");
  // Auto mode and list restart.
  a_auto_first_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R6
    config_reg[`CFG_AUTO_BIT] && !auto_cmp_reg && state_reg == integrity_monitor_pkg::ST_DIG
    |-> digest_write_o) else $error("first auto pass did not write back");
  a_auto_no_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R8
    config_reg[`CFG_AUTO_BIT] && state_reg == integrity_monitor_pkg::ST_NEXT && enable_reg &&
    !(avs_write_i && ack_reg) |=> enable_reg)
    else $error("auto run stopped by an end flag");
  a_wrap_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // R24
    state_reg == integrity_monitor_pkg::ST_NEXT && cnt_reg <= 16'h1 && region_cfg_reg[`RC_WRAP_BIT] &&
    enable_reg && !srst |=> state_reg == integrity_monitor_pkg::ST_CFG && desc_ptr_reg == desc_base_reg)
    else $error("wrap did not restart at the list head");
  // Main scenarios that the bench should reach.
  c_wrap: cover property (@(posedge ref_clk_i) auto_cmp_reg);
  c_undef: cover property (@(posedge ref_clk_i) flag_reg);
  c_mismatch: cover property (@(posedge ref_clk_i) mismatch_reg);
  c_secondary: cover property (@(posedge ref_clk_i) in_sec_reg && hash_start_o);
endmodule
`default_nettype wire

// *** verilog/integrity_monitor_defs.svh ***
/*
  Offsets, field positions, access codes and timing counts of the list control.
  Assumes a 10 MHz system clock and a 32-bit byte-addressed register bus.
*/
`ifndef INTEGRITY_MONITOR_DEFS_SVH
`define INTEGRITY_MONITOR_DEFS_SVH
// ==========================================================================
// Register byte offsets.
`define OFS_CONFIG 8'h00
`define OFS_CONTROL 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h1c
`define OFS_UNDEF_STATUS 8'h20
`define OFS_DESC_BASE 8'h30
`define OFS_DIGEST_BASE 8'h34
`define OFS_PERIOD 8'h40
// ==========================================================================
// Config fields.
`define CFG_EOMDIS_BIT 1
`define CFG_SLBDIS_BIT 2
`define CFG_BBC_LSB 4
`define CFG_AUTO_BIT 8
`define CFG_ALGO_LSB 13
// Control fields.
`define CTL_ENABLE_BIT 0
`define CTL_DISABLE_BIT 1
`define CTL_SRST_BIT 2
// Region config word fields.
`define RC_CMP_BIT 8
`define RC_WRAP_BIT 9
`define RC_EOM_BIT 10
`define RC_RSVD_MASK 32'hfffff8ff
// Access type codes.
`define UAT_DESC 3'h1
`define UAT_CFG 3'h2
`define UAT_DSCR 3'h3
`define UAT_HASH 3'h4
`define UAT_RDWO 3'h5
// ==========================================================================
// Period limits in clock cycles, start synchronisation, burden limit and digest shift.
`define SHA1_MIN_CYC 85
`define SHA1_MAX_CYC 209
`define SHA2_MIN_CYC 72
`define SHA2_MAX_CYC 194
`define SYNC_CYC 2
`define BBC_MAX_CYC 32768
`define DIGEST_SHIFT 5
`endif

// *** verilog/integrity_monitor_pkg.sv ***
/*
  Types of the list control.
  Assumes the defs header supplies all numbers except the state encodings defined here.
*/
`default_nettype none
package integrity_monitor_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CFG = 8'h02,
    ST_LINK = 8'h04,
    ST_BLK = 8'h08,
    ST_HASH = 8'h10,
    ST_DIG = 8'h20,
    ST_GAP = 8'h40,
    ST_NEXT = 8'h80
  } state_t;
endpackage
`default_nettype wire
